// ==== src/pnp_pkg.sv ====
// Shared constants and types for the parallel nibble port.
package pnp_pkg;

  // Clock rate and the timing figures derived from it.
  localparam int CLK_MHZ          = 200;
  localparam int ACK_PULSE_NS     = 2000;
  localparam int ACK_CYCLES       = (ACK_PULSE_NS * CLK_MHZ) / 1000;
  localparam int NIB_SETUP_NS     = 500;
  localparam int NIB_SETUP_CYCLES = (NIB_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W            = 16;

  // Extensibility request values that get an affirmative reply.
  localparam logic [7:0] EXT_NIBBLE    = 8'h00;
  localparam logic [7:0] EXT_DEVICE_ID = 8'h04;

  // Bit positions inside the synchronised pin vector.
  localparam int SY_DATA_LSB = 0;
  localparam int SY_INIT     = 8;
  localparam int SY_ACTIVE   = 9;
  localparam int SY_HOLD     = 10;
  localparam int SY_STROBE   = 11;
  localparam int SY_W        = 12;

  // Identification string pieces. The maker and model texts are arbitrary.
  localparam logic [8*20-1:0] ID_HEAD    = "MFG:ACME;CMD:ESC,BDC";
  localparam logic [8*4-1:0]  ID_PKT     = ",PKT";
  localparam logic [8*5-1:0]  ID_MDL     = ";MDL:";
  localparam logic [8*7-1:0]  ID_MODEL_A = "MODEL-A";
  localparam logic [8*7-1:0]  ID_MODEL_B = "MODEL-B";
  localparam logic [8*22-1:0] ID_CLS     = ";CLS:PRINTER;DES:ACME ";
  localparam logic [8*1-1:0]  ID_END     = ";";
  localparam int ID_LEN_BASE = 62;
  localparam int ID_LEN_PKT  = 66;
  localparam logic [7:0] ID_TOTAL_BASE = 8'(ID_LEN_BASE + 2);
  localparam logic [7:0] ID_TOTAL_PKT  = 8'(ID_LEN_PKT + 2);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FWD_TAKE,
    ST_FWD_ACK,
    ST_NEG_ACK,
    ST_REJECT,
    ST_REV_IDLE,
    ST_REV_SETUP,
    ST_REV_CLK_LO
  } pnp_state_t;

  typedef struct packed {
    pnp_state_t       state;
    logic [SY_W-1:0]  sync1;
    logic [SY_W-1:0]  sync2;
    logic             strb_prev;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       ext_byte;
    logic             id_mode;
    logic [7:0]       id_idx;
    logic [7:0]       rev_byte;
    logic             have_byte;
    logic             high_nib;
    logic [7:0]       rx_data;
    logic             rx_valid;
    logic             busy;
    logic             ack_n;
    logic             ack_req;
    logic             xflag;
    logic             avail_n;
  } pnp_regs_t;

endpackage

// ==== src/pnp_id_rom.sv ====
// Identification string source: length prefix followed by the text fields.
`timescale 1ns/1ps
module pnp_id_rom
  import pnp_pkg::*;
(
  // Lookup
  input  wire logic [7:0] idx_in,
  input  wire logic       pkt_en_in,
  input  wire logic       model_sel_in,
  // Result
  output logic      [7:0] byte_out,
  output logic      [7:0] total_out
);

  logic [8*7-1:0]          model;
  logic [8*ID_LEN_PKT-1:0]  str_pkt;
  logic [8*ID_LEN_BASE-1:0] str_base;

  assign model     = model_sel_in ? ID_MODEL_B : ID_MODEL_A;
  assign str_pkt   = {ID_HEAD, ID_PKT, ID_MDL, model, ID_CLS, model, ID_END};
  assign str_base  = {ID_HEAD, ID_MDL, model, ID_CLS, model, ID_END};
  assign total_out = pkt_en_in ? ID_TOTAL_PKT : ID_TOTAL_BASE;

  always_comb begin
    int b;
    b = int'(idx_in) - 2;
    byte_out = 8'h00;
    // The two-byte length counts itself and goes out high byte first.
    if (idx_in == 8'h01) begin
      byte_out = total_out;
    end else if (idx_in >= 8'h02) begin
      if (pkt_en_in && b < ID_LEN_PKT) begin
        byte_out = str_pkt[8*(ID_LEN_PKT-1-b) +: 8];
      end else if (!pkt_en_in && b < ID_LEN_BASE) begin
        byte_out = str_base[8*(ID_LEN_BASE-1-b) +: 8];
      end
    end
  end

endmodule

// ==== src/pnp_port.sv ====
// Printer-side parallel port: forward byte handshake and nibble reverse channel.
`timescale 1ns/1ps
module pnp_port
  import pnp_pkg::*;
#(
  parameter int ACK_CYC   = ACK_CYCLES,
  parameter int SETUP_CYC = NIB_SETUP_CYCLES
)(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // Pins from the host
  input  wire logic       host_clock_line_n_in,
  input  wire logic [7:0] data_in,
  input  wire logic       host_hold_line_in,
  input  wire logic       active_1284_in,
  input  wire logic       init_n_in,
  // Pins to the host
  output logic            byte_ack_pulse_n_out,
  output logic            printer_busy_line_out,
  output logic            reverse_ack_request_line_out,
  output logic            xflag_line_out,
  output logic            reverse_data_available_line_n_out,
  // Received forward data
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  // Printer status and options
  input  wire logic       error_in,
  input  wire logic       paper_out_in,
  input  wire logic       pkt_proto_en_in,
  input  wire logic       model_sel_in,
  // Reverse data for nibble transfers
  input  wire logic [7:0] rev_data_in,
  input  wire logic       rev_valid_in,
  output logic            rev_ready_out
);

  localparam logic [CNT_W-1:0] ACK_LAST   = CNT_W'(ACK_CYC - 1);
  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYC - 1);

  pnp_regs_t r;
  pnp_regs_t n;

  logic       strobe_n;
  logic       hold;
  logic       active;
  logic       init_n;
  logic [7:0] data_s;
  logic       strobe_fall;
  logic [7:0] id_byte;
  logic [7:0] id_total;
  logic [3:0] nib;

  // Only the second synchroniser stage feeds any logic.
  assign strobe_n    = r.sync2[SY_STROBE];
  assign hold        = r.sync2[SY_HOLD];
  assign active      = r.sync2[SY_ACTIVE];
  assign init_n      = r.sync2[SY_INIT];
  assign data_s      = r.sync2[SY_DATA_LSB +: 8];
  assign strobe_fall = r.strb_prev && !strobe_n;
  assign nib         = r.high_nib ? r.rev_byte[7:4] : r.rev_byte[3:0];

  pnp_id_rom u_id_rom (
    .idx_in       (r.id_idx),
    .pkt_en_in    (pkt_proto_en_in),
    .model_sel_in (model_sel_in),
    .byte_out     (id_byte),
    .total_out    (id_total)
  );

  // Plain nibble mode takes a byte whenever the channel is empty between nibbles.
  assign rev_ready_out = (r.state == ST_REV_IDLE) && !r.have_byte && !r.id_mode;

  always_comb begin
    n           = r;
    n.sync1     = {host_clock_line_n_in, host_hold_line_in, active_1284_in, init_n_in,
                   data_in};
    n.sync2     = r.sync1;
    n.strb_prev = strobe_n;
    n.rx_valid  = 1'b0;

    case (r.state)
      ST_IDLE: begin
        // Compatibility levels: select high, fault mirrors error, paper-out on its line.
        n.ack_n   = 1'b1;
        n.xflag   = 1'b1;
        n.ack_req = paper_out_in;
        n.avail_n = !error_in;
        n.busy    = error_in || !rx_ready_in;
        if (active && !hold) begin
          // Negotiation: the request value is on the data lines already.
          n.ext_byte = data_s;
          n.ack_n    = 1'b0;
          n.ack_req  = 1'b1;
          n.avail_n  = 1'b1;
          n.xflag    = 1'b1;
          n.state    = ST_NEG_ACK;
        end else if (!init_n) begin
          n.busy = 1'b1;
        end else if (strobe_fall && !r.busy) begin
          // A strobe seen while busy is dropped; the host must not send then.
          n.rx_data  = data_s;
          n.rx_valid = 1'b1;
          n.busy     = 1'b1;
          n.state    = ST_FWD_TAKE;
        end
      end

      ST_FWD_TAKE: begin
        // Busy stays high until the strobe has returned and the acknowledge is done.
        if (strobe_n) begin
          n.ack_n = 1'b0;
          n.cnt   = ACK_LAST;
          n.state = ST_FWD_ACK;
        end
      end

      ST_FWD_ACK: begin
        if (r.cnt == '0) begin
          n.ack_n = 1'b1;
          n.busy  = error_in || !rx_ready_in;
          n.state = ST_IDLE;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end

      ST_NEG_ACK: begin
        if (hold && strobe_n) begin
          n.ack_n     = 1'b1;
          n.ack_req   = 1'b0;
          n.busy      = 1'b0;
          n.have_byte = 1'b0;
          n.high_nib  = 1'b0;
          n.id_idx    = 8'h00;
          n.id_mode   = (r.ext_byte == EXT_DEVICE_ID);
          if (r.ext_byte == EXT_NIBBLE || r.ext_byte == EXT_DEVICE_ID) begin
            n.xflag   = 1'b1;
            n.avail_n = !(r.ext_byte == EXT_DEVICE_ID);
            n.state   = ST_REV_IDLE;
          end else begin
            n.xflag   = 1'b0;
            n.avail_n = 1'b1;
            n.state   = ST_REJECT;
          end
        end
      end

      ST_REJECT: begin
        n.xflag = 1'b0;
      end

      ST_REV_IDLE: begin
        n.ack_n   = 1'b1;
        n.ack_req = 1'b0;
        n.busy    = 1'b0;
        n.xflag   = 1'b1;
        if (!r.have_byte) begin
          if (r.id_mode && r.id_idx < id_total) begin
            n.rev_byte  = id_byte;
            n.id_idx    = r.id_idx + 1'b1;
            n.have_byte = 1'b1;
          end else if (!r.id_mode && rev_valid_in) begin
            n.rev_byte  = rev_data_in;
            n.have_byte = 1'b1;
          end
        end
        n.avail_n = !n.have_byte;
        if (!hold && r.have_byte) begin
          n.busy    = nib[3];
          n.ack_req = nib[2];
          n.xflag   = nib[1];
          n.avail_n = nib[0];
          n.cnt     = SETUP_LAST;
          n.state   = ST_REV_SETUP;
        end
      end

      ST_REV_SETUP: begin
        // Nibble lines settle before the printer clock falls.
        if (r.cnt == '0) begin
          n.ack_n = 1'b0;
          n.state = ST_REV_CLK_LO;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end

      ST_REV_CLK_LO: begin
        if (hold) begin
          n.ack_n = 1'b1;
          if (r.high_nib) begin
            n.high_nib  = 1'b0;
            n.have_byte = 1'b0;
          end else begin
            n.high_nib = 1'b1;
          end
          n.state = ST_REV_IDLE;
        end
      end

      default: begin
        n.state = ST_IDLE;
      end
    endcase

    // Dropping the 1284 active line ends any negotiated mode at once.
    if (!active && (r.state == ST_NEG_ACK || r.state == ST_REJECT ||
                    r.state == ST_REV_IDLE || r.state == ST_REV_SETUP ||
                    r.state == ST_REV_CLK_LO)) begin
      n.ack_n     = 1'b1;
      n.busy      = 1'b1;
      n.have_byte = 1'b0;
      n.high_nib  = 1'b0;
      n.state     = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r           <= '0;
      r.state     <= ST_IDLE;
      r.sync1     <= {1'b1, 1'b1, 1'b0, 1'b1, 8'h00};
      r.sync2     <= {1'b1, 1'b1, 1'b0, 1'b1, 8'h00};
      r.strb_prev <= 1'b1;
      r.busy      <= 1'b1;
      r.ack_n     <= 1'b1;
      r.xflag     <= 1'b1;
      r.avail_n   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign byte_ack_pulse_n_out              = r.ack_n;
  assign printer_busy_line_out             = r.busy;
  assign reverse_ack_request_line_out      = r.ack_req;
  assign xflag_line_out                    = r.xflag;
  assign reverse_data_available_line_n_out = r.avail_n;
  assign rx_data_out                       = r.rx_data;
  assign rx_valid_out                      = r.rx_valid;

endmodule

// ==== verif/pnp_checker.sv ====
// Concurrent checks on the parallel nibble port pins.
`timescale 1ns/1ps
module pnp_checker #(
  parameter int ACK_CYC = 2
)(
  // Clock, reset and inputs
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic active_1284_in,
  input wire logic error_in,
  input wire logic rx_ready_in,
  // Outputs of the port
  input wire logic byte_ack_pulse_n_out,
  input wire logic printer_busy_line_out,
  input wire logic reverse_ack_request_line_out,
  input wire logic xflag_line_out,
  input wire logic reverse_data_available_line_n_out,
  input wire logic rx_valid_out
);
  wire       ack = byte_ack_pulse_n_out;
  wire       bsy = printer_busy_line_out;
  wire       act = active_1284_in;
  wire [3:0] nib = {bsy, reverse_ack_request_line_out, xflag_line_out,
                    reverse_data_available_line_n_out};
  logic [15:0] ack_lo_r;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      ack_lo_r <= 16'h0;
    else
      ack_lo_r <= ack ? 16'h0 : ack_lo_r + 16'h1;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_rx_pulse; rx_valid_out |=> !rx_valid_out; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse too long");
  property p_rx_take; rx_valid_out |-> !$past(bsy) && bsy; endproperty
  a_rx_take: assert property (p_rx_take) else $error("byte taken while busy");
  property p_ack_after; rx_valid_out |-> ##[1:300] !ack; endproperty
  a_ack_after: assert property (p_ack_after) else $error("no ack after byte");
  property p_ack_len; $rose(ack) && !act |-> ack_lo_r == ACK_CYC; endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack width wrong");
  property p_ack_busy; !ack && !act |-> bsy; endproperty
  a_ack_busy: assert property (p_ack_busy) else $error("busy low in ack");
  property p_ack_free; $rose(ack) && !act && !error_in && rx_ready_in |-> !bsy; endproperty
  a_ack_free: assert property (p_ack_free) else $error("busy stuck after ack");
  property p_err_busy; (error_in && !act) [*4] |-> bsy && !nib[0]; endproperty
  a_err_busy: assert property (p_err_busy) else $error("error not shown");
  property p_full_busy; (!rx_ready_in && !act) [*4] |-> bsy; endproperty
  a_full_busy: assert property (p_full_busy) else $error("busy low when full");
  property p_rev_hold; !ack && !$past(ack) && act |-> $stable(nib); endproperty
  a_rev_hold: assert property (p_rev_hold) else $error("nibble moved");
endmodule

bind pnp_port pnp_checker #(.ACK_CYC(ACK_CYC)) u_chk (.sys_clk_in, .rst_b_in,
  .active_1284_in, .error_in, .rx_ready_in, .byte_ack_pulse_n_out,
  .printer_busy_line_out, .reverse_ack_request_line_out, .xflag_line_out,
  .reverse_data_available_line_n_out, .rx_valid_out);

// ==== verif/pnp_host_model.sv ====
// Host-side parallel port model: strobed bytes, negotiation, nibble reads.
`timescale 1ns/1ps
module pnp_host_model (
  // Clock
  input  wire logic       sys_clk_in,
  // To the port
  output logic            strobe_n_out,
  output logic      [7:0] data_out,
  output logic            hold_out,
  output logic            active_out,
  // From the port: busy, request, flag, available
  input  wire logic       ack_n_in,
  input  wire logic [3:0] lines_in
);
  initial begin
    strobe_n_out = 1'b1;
    data_out = 8'h00;
    hold_out = 1'b1;
    active_out = 1'b0;
  end
  task automatic w_ack(input logic lvl);
    for (int i = 0; i < 3000 && ack_n_in !== lvl; i++) @(posedge sys_clk_in);
  endtask
  // Strobe is held 100 cycles, the minimum width at 200 MHz.
  task automatic send_byte(input logic [7:0] b, input bit paced);
    for (int i = 0; paced && i < 3000 && lines_in[3] !== 1'b0; i++) @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    data_out <= b;
    strobe_n_out <= 1'b0;
    repeat (100) @(posedge sys_clk_in);
    strobe_n_out <= 1'b1;
    if (paced) w_ack(1'b0);
    if (paced) w_ack(1'b1);
    data_out <= ~b;
  endtask
  task automatic negotiate(input logic [7:0] v);
    @(posedge sys_clk_in);
    data_out <= v;
    active_out <= 1'b1;
    hold_out <= 1'b0;
    w_ack(1'b0);
    hold_out <= 1'b1;
    w_ack(1'b1);
    repeat (2) @(posedge sys_clk_in);
  endtask
  task automatic read_byte(output logic [7:0] b);
    for (int k = 0; k < 2; k++) begin
      hold_out <= 1'b0;
      w_ack(1'b0);
      b = {lines_in, b[7:4]};
      hold_out <= 1'b1;
      w_ack(1'b1);
    end
  endtask
  task automatic end_session();
    @(posedge sys_clk_in);
    active_out <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
  endtask
endmodule

// ==== verif/parallel_nibble_port_test.sv ====
// Self-checking testbench for the parallel nibble port.
`timescale 1ns/1ps
module parallel_nibble_port_test;
  logic       clk, rst_b, stb_n, hold, act, ack_n, bsy, req, xf, av_n;
  logic       rx_v, rx_rdy, err, paper, pkt, mdl, rv_v, rv_rdy, loop, init_n;
  logic [7:0] dat, rx_d, rv_d, rx_seen, n_rx;
  int         fail_count, n_compared;
  // Fixed data levels for the busy-to-strobe loopback self test.
  localparam logic [7:0] LOOP_D = 8'h81;
  pnp_port #(.ACK_CYC(2), .SETUP_CYC(1)) dut (.sys_clk_in(clk), .rst_b_in(rst_b),
    .host_clock_line_n_in(loop ? bsy : stb_n), .data_in(loop ? LOOP_D : dat),
    .host_hold_line_in(hold), .active_1284_in(act), .init_n_in(init_n),
    .byte_ack_pulse_n_out(ack_n),
    .printer_busy_line_out(bsy), .reverse_ack_request_line_out(req),
    .xflag_line_out(xf), .reverse_data_available_line_n_out(av_n),
    .rx_data_out(rx_d), .rx_valid_out(rx_v), .rx_ready_in(rx_rdy), .error_in(err),
    .paper_out_in(paper), .pkt_proto_en_in(pkt), .model_sel_in(mdl),
    .rev_data_in(rv_d), .rev_valid_in(rv_v), .rev_ready_out(rv_rdy));
  pnp_host_model host (.sys_clk_in(clk), .strobe_n_out(stb_n), .data_out(dat),
    .hold_out(hold), .active_out(act), .ack_n_in(ack_n), .lines_in({bsy, req, xf, av_n}));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The reverse byte is withdrawn on the edge that hands it over.
  always @(posedge clk) begin
    if (rx_v === 1'b1) begin
      rx_seen = rx_d;
      n_rx++;
    end
    if (rv_v && rv_rdy) rv_v <= 1'b0;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_fwd(input logic [7:0] b, input logic [7:0] cnt);
    host.send_byte(b, 1'b1);
    chk("rx_data", rx_seen, b);
    chk("rx_count", n_rx, cnt);
    chk("busy_ready", bsy, 1'b0);
  endtask
  task automatic t_hold_off();
    @(posedge clk);
    rx_rdy <= 1'b0;
    paper <= 1'b1;
    repeat (6) @(posedge clk);
    chk("busy_full", bsy, 1'b1);
    chk("paper_line", req, 1'b1);
    host.send_byte(8'hc3, 1'b0);
    repeat (20) @(posedge clk);
    chk("rx_refused", n_rx, 8'h01);
    rx_rdy <= 1'b1;
    err <= 1'b1;
    repeat (6) @(posedge clk);
    chk("busy_error", bsy, 1'b1);
    chk("error_line", av_n, 1'b0);
    err <= 1'b0;
    paper <= 1'b0;
    init_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("busy_init", bsy, 1'b1);
    init_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // Busy drives strobe, so every finished acknowledge starts the next byte.
  task automatic t_loop();
    logic [7:0] n0;
    @(posedge clk);
    n0 = n_rx;
    loop <= 1'b1;
    repeat (80) @(posedge clk);
    loop <= 1'b0;
    repeat (20) @(posedge clk);
    chk("loop_data", rx_seen, LOOP_D);
    chk("loop_runs", {7'h00, (n_rx - n0) >= 8'd5}, 8'h01);
    chk("loop_idle", bsy, 1'b0);
  endtask
  task automatic t_id(input logic p, input logic m, input string s);
    logic [7:0] b;
    @(posedge clk);
    pkt <= p;
    mdl <= m;
    host.negotiate(8'h04);
    chk("id_xflag", xf, 1'b1);
    chk("id_avail", av_n, 1'b0);
    host.read_byte(b);
    chk("id_len_hi", b, 8'h00);
    host.read_byte(b);
    chk("id_len_lo", b, 8'(s.len() + 2));
    for (int i = 0; i < s.len(); i++) begin
      host.read_byte(b);
      chk("id_text", b, s[i]);
    end
    repeat (2) @(posedge clk);
    chk("id_done", av_n, 1'b1);
    host.end_session();
  endtask
  task automatic t_nibble();
    logic [7:0] b;
    host.negotiate(8'h00);
    chk("nib_xflag", xf, 1'b1);
    rv_d <= 8'h96;
    rv_v <= 1'b1;
    repeat (4) @(posedge clk);
    chk("nib_avail", av_n, 1'b0);
    host.read_byte(b);
    chk("nib_byte", b, 8'h96);
    host.end_session();
  endtask
  task automatic t_reject(input logic [7:0] v);
    host.negotiate(v);
    chk("rej_xflag", xf, 1'b0);
    host.end_session();
  endtask
  initial begin
    rst_b = 1'b0;
    {rx_rdy, err, paper, pkt, mdl, rv_v} = 6'h20;
    {rv_d, n_rx, rx_seen} = 24'h0;
    {loop, init_n} = 2'b01;
    fail_count = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_fwd(8'h5a, 8'h01);
    t_hold_off();
    t_fwd(8'ha5, 8'h02);
    t_loop();
    t_id(1'b0, 1'b0, "MFG:ACME;CMD:ESC,BDC;MDL:MODEL-A;CLS:PRINTER;DES:ACME MODEL-A;");
    t_id(1'b1, 1'b1, "MFG:ACME;CMD:ESC,BDC,PKT;MDL:MODEL-B;CLS:PRINTER;DES:ACME MODEL-B;");
    t_nibble();
    t_reject(8'h14);
    t_reject(8'h01);
    end_sim();
  end
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
endmodule
